// ### hw/sbc_pkg.sv
// Constants, enumerations and state records shared by both ends of the supervision link.
// Assumes a single 100 MHz clock for every module that imports it.
package sbc_pkg;
  localparam int unsigned SBC_CLK_MHZ     = 100;
  localparam int unsigned SBC_RST_PULSE_US = 1000;
  localparam int unsigned SBC_CLT_US      = 256;
  localparam int unsigned SBC_CHT_US      = 256;
  localparam int unsigned SBC_TXD_DOM_US  = 20;
  localparam int unsigned SBC_LIN_DOM_US  = 40;
  localparam int unsigned SBC_REC_US      = 10;
  localparam int unsigned SBC_V3_P1_US    = 16000;
  localparam int unsigned SBC_V3_P2_US    = 32000;
  localparam int unsigned SBC_V3_ON_US    = 1000;
  localparam logic [23:0] SBC_RST_PULSE_CYC = 24'(SBC_RST_PULSE_US * SBC_CLK_MHZ);
  localparam logic [23:0] SBC_CLT_CYC       = 24'(SBC_CLT_US * SBC_CLK_MHZ);
  localparam logic [23:0] SBC_CHT_CYC       = 24'(SBC_CHT_US * SBC_CLK_MHZ);
  localparam logic [23:0] SBC_V3_P1_CYC     = 24'(SBC_V3_P1_US * SBC_CLK_MHZ);
  localparam logic [23:0] SBC_V3_P2_CYC     = 24'(SBC_V3_P2_US * SBC_CLK_MHZ);
  localparam logic [23:0] SBC_V3_ON_CYC     = 24'(SBC_V3_ON_US * SBC_CLK_MHZ);
  localparam logic [15:0] SBC_TXD_DOM_CYC   = 16'(SBC_TXD_DOM_US * SBC_CLK_MHZ);
  localparam logic [15:0] SBC_LIN_DOM_CYC   = 16'(SBC_LIN_DOM_US * SBC_CLK_MHZ);
  localparam logic [15:0] SBC_REC_CYC       = 16'(SBC_REC_US * SBC_CLK_MHZ);
  localparam logic [2:0]  SBC_CHATTER_MAX   = 3'h4;

  typedef enum logic [2:0] {
    SBC_M_START    = 3'b000,
    SBC_M_NORMAL   = 3'b001,
    SBC_M_FLASH    = 3'b010,
    SBC_M_STANDBY  = 3'b011,
    SBC_M_SLEEP    = 3'b100,
    SBC_M_FAILSAFE = 3'b101
  } sbc_mode_t;

  typedef enum logic [2:0] {
    SBC_SRC_POR     = 3'b000,
    SBC_SRC_UV      = 3'b001,
    SBC_SRC_EXT     = 3'b010,
    SBC_SRC_V3      = 3'b011,
    SBC_SRC_WAKE    = 3'b100,
    SBC_SRC_CLAMP   = 3'b101,
    SBC_SRC_CHATTER = 3'b110
  } sbc_src_t;

  typedef enum logic [1:0] {
    SBC_TERM_OFF  = 2'b00,
    SBC_TERM_ON   = 2'b01,
    SBC_TERM_WEAK = 2'b10
  } sbc_term_t;

  localparam logic [1:0] SBC_V3_OFF = 2'h0;
  localparam logic [1:0] SBC_V3_ON  = 2'h1;
  localparam logic [1:0] SBC_V3_CY1 = 2'h2;
  localparam logic [1:0] SBC_V3_CY2 = 2'h3;

  localparam logic [3:0] SBC_A_CTRL   = 4'h0;
  localparam logic [3:0] SBC_A_MODE   = 4'h4;
  localparam logic [3:0] SBC_A_STATUS = 4'h8;
  localparam logic [3:0] SBC_A_EVENTS = 4'hc;

  localparam int SBC_C_GATE  = 0;
  localparam int SBC_C_TAR   = 1;
  localparam int SBC_C_TS    = 2;
  localparam int SBC_C_SLOPE = 3;
  localparam int SBC_C_BOOST = 4;
  localparam int SBC_C_AUXA  = 5;
  localparam int SBC_C_AUXF  = 6;
  localparam int SBC_C_V3    = 7;
  localparam int SBC_C_UV    = 9;
  localparam int SBC_C_TXD   = 11;
  localparam int SBC_C_HRST  = 12;
  localparam logic [12:0] SBC_CTRL_RST = 13'h0800;

  typedef struct packed {
    logic [7:0]  s1;
    logic [7:0]  s2;
    sbc_mode_t   mode;
    sbc_src_t    rsrc;
    logic        rst_drive;
    logic        rel_watch;
    logic        line_q;
    logic [23:0] rst_cnt;
    logic [23:0] clamp_cnt;
    logic [2:0]  chatter;
    logic        gate;
    logic        warn_q;
    logic [1:0]  v3_mode_q;
    logic        v3_fault;
    logic [23:0] v3_cnt;
    logic        ts_q;
    logic        bdom_q;
    logic [15:0] txd_cnt;
    logic        txd_fault;
    logic [15:0] rec_cnt;
    logic        rec_fault;
    logic [15:0] dom_cnt;
    logic        short_gnd;
    logic        lin_wake;
    logic [2:0]  evt;
    logic        reg_on;
    logic        v3_on;
    logic        wsamp;
    logic        txdrive;
    logic        rx;
    sbc_term_t   term;
    logic        slope;
    logic        boost;
    logic        aux_out;
    logic        aux_oe_b;
  } sbc_dev_st_t;

  localparam sbc_dev_st_t SBC_DEV_RST = '{mode: SBC_M_START, rsrc: SBC_SRC_POR, rst_drive: 1'b1,
                                        rx: 1'b1, term: SBC_TERM_OFF, aux_oe_b: 1'b1, default: '0};

  typedef struct packed {
    logic        s1;
    logic        s2;
    logic [12:0] ctrl;
    logic [2:0]  sticky;
    logic        ack;
    logic [31:0] rdata;
    logic        mode_stb;
    logic [2:0]  mode_req;
  } sbc_host_st_t;

  localparam sbc_host_st_t SBC_HOST_RST = '{ctrl: SBC_CTRL_RST, s1: 1'b1, s2: 1'b1, default: '0};
endpackage

// ### hw/sbc_link_if.sv
// Link between the supervision device and its host controller.
// The open-drain reset line is resolved here; a bench may clamp it with the two clamp signals.
`timescale 1ns/100ps
interface sbc_link_if;
  import sbc_pkg::*;
  logic       dev_rst_o;
  logic       dev_rst_oe_b;
  logic       host_rst_o;
  logic       host_rst_oe_b;
  logic       tb_clamp_low;
  logic       tb_clamp_high;
  logic       rst_line;
  logic       gate_req;
  logic       tar;
  logic       ts;
  logic       slope_low;
  logic       boost;
  logic       aux_act;
  logic       aux_func;
  logic [1:0] v3_mode;
  logic [1:0] uv_sel;
  logic [2:0] mode_req;
  logic       mode_stb;
  logic       txd;
  logic [2:0] mode;
  logic [2:0] rsrc;
  logic [3:0] diag;
  logic [2:0] evt;
  logic       en_pin;
  logic       rxd;

  assign rst_line = tb_clamp_high ? 1'b1 :
                    tb_clamp_low ? 1'b0 :
                    !((!dev_rst_oe_b && !dev_rst_o) || (!host_rst_oe_b && !host_rst_o));

  modport dev (output dev_rst_o, dev_rst_oe_b, mode, rsrc, diag, evt, en_pin, rxd,
               input rst_line, gate_req, tar, ts, slope_low, boost, aux_act, aux_func, v3_mode, uv_sel,
               mode_req, mode_stb, txd);
  modport host (output host_rst_o, host_rst_oe_b, gate_req, tar, ts, slope_low, boost, aux_act, aux_func,
                v3_mode, uv_sel, mode_req, mode_stb, txd,
                input rst_line, mode, rsrc, diag, evt, en_pin, rxd);
endinterface

// ### hw/sbc_dev.sv
// Supervision device: reset line watch, supply and switched output control, bus transceiver control.
// Assumes analog comparator levels arrive asynchronously and the host end shares clk.
`timescale 1ns/100ps
module sbc_dev
  import sbc_pkg::*;
#(
  parameter logic [23:0] RST_PULSE_CYC = SBC_RST_PULSE_CYC,
  parameter logic [23:0] CLT_CYC       = SBC_CLT_CYC,
  parameter logic [23:0] CHT_CYC       = SBC_CHT_CYC,
  parameter logic [23:0] V3_P1_CYC     = SBC_V3_P1_CYC,
  parameter logic [23:0] V3_P2_CYC     = SBC_V3_P2_CYC,
  parameter logic [23:0] V3_ON_CYC     = SBC_V3_ON_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       ce,
  sbc_link_if.dev         link,
  input  wire logic [2:0] v1_uv,
  input  wire logic       v1_warn_cmp,
  input  wire logic       v3_overload,
  input  wire logic       wake_in,
  input  wire logic       lin_bus_dom,
  output logic            mcu_supply_regulator,
  output logic            supply_request_out,
  output logic            supply_request_out_oe_b,
  output logic            switched_battery_out,
  output logic            wake_sample_en,
  output logic            lin_tx_drive,
  output logic            lin_slope_low,
  output logic            lin_drive_boost,
  output sbc_term_t       bus_termination_pin,
  output logic            external_regulator_ctrl_pin,
  output logic            external_regulator_ctrl_pin_oe_b
);
  sbc_dev_st_t s;
  sbc_dev_st_t next_s;
  logic        line;
  logic [2:0]  uv;
  logic        warn;
  logic        ovl;
  logic        wake;
  logic        bdom;
  logic        run;
  logic        active;
  logic        tx_en;
  logic        txd_dom;
  logic        ts_rel;
  logic        bus_edge;
  logic        uv_hit;
  logic        ext_fall;
  logic        v3_sleep;
  logic        wake_sleep;
  logic        v3_raw;
  logic        to_fs;
  logic [23:0] v3_per;

  always_comb begin
    next_s = s;
    next_s.s1 = {link.rst_line, v1_uv, v1_warn_cmp, v3_overload, wake_in, lin_bus_dom};
    next_s.s2 = s.s1;
    {line, uv, warn, ovl, wake, bdom} = s.s2;
    next_s.line_q = line;
    next_s.evt = '0;
    run = (s.mode == SBC_M_NORMAL) || (s.mode == SBC_M_FLASH);
    to_fs = 1'b0;

    if (link.mode_stb && !s.rst_drive && (s.mode != SBC_M_FAILSAFE) &&
        (link.mode_req inside {SBC_M_NORMAL, SBC_M_FLASH, SBC_M_STANDBY, SBC_M_SLEEP})) begin
      next_s.mode = sbc_mode_t'(link.mode_req);
      if (link.mode_req == SBC_M_NORMAL) begin
        next_s.chatter = '0;
      end
    end

    uv_hit = s.reg_on && (link.uv_sel != 2'h3) && uv[link.uv_sel];
    next_s.warn_q = warn;
    if (warn && !s.warn_q && (link.uv_sel != 2'h0)) begin
      next_s.evt[2] = 1'b1;
    end

    v3_per = (link.v3_mode == SBC_V3_CY1) ? V3_P1_CYC : V3_P2_CYC;
    next_s.v3_cnt = (s.v3_cnt >= v3_per - 24'h1) ? 24'h0 : s.v3_cnt + 24'h1;
    v3_raw = (link.v3_mode == SBC_V3_ON) || ((link.v3_mode[1]) && (s.v3_cnt < V3_ON_CYC));
    next_s.v3_mode_q = link.v3_mode;
    if (link.v3_mode != s.v3_mode_q) begin
      next_s.v3_fault = 1'b0;
    end
    v3_sleep = 1'b0;
    if (ovl && s.v3_on) begin
      next_s.v3_fault = 1'b1;
      next_s.evt[1] = 1'b1;
      v3_sleep = (s.mode == SBC_M_SLEEP);
    end

    ext_fall = s.line_q && !line && !s.rst_drive && !s.rel_watch && (s.mode != SBC_M_FAILSAFE);
    wake_sleep = (s.mode == SBC_M_SLEEP) && (wake || s.lin_wake);
    if (ext_fall) begin
      next_s.chatter = s.chatter + 3'h1;
    end

    if (s.mode == SBC_M_FAILSAFE) begin
      if (wake) begin
        next_s.mode = SBC_M_START;
        next_s.rst_cnt = '0;
        next_s.rsrc = SBC_SRC_WAKE;
        next_s.chatter = '0;
      end
    end else if (ext_fall && (next_s.chatter >= SBC_CHATTER_MAX)) begin
      to_fs = 1'b1;
      next_s.rsrc = SBC_SRC_CHATTER;
    end else if (uv_hit || ext_fall || v3_sleep || wake_sleep) begin
      next_s.rst_drive = 1'b1;
      next_s.rel_watch = 1'b0;
      next_s.rst_cnt = '0;
      next_s.clamp_cnt = '0;
      next_s.mode = SBC_M_START;
      next_s.rsrc = uv_hit ? SBC_SRC_UV : v3_sleep ? SBC_SRC_V3 : ext_fall ? SBC_SRC_EXT : SBC_SRC_WAKE;
    end else if (s.rst_drive) begin
      next_s.rst_cnt = s.rst_cnt + 24'h1;
      next_s.clamp_cnt = line ? s.clamp_cnt + 24'h1 : 24'h0;
      if (line && (s.clamp_cnt >= CHT_CYC - 24'h1)) begin
        to_fs = 1'b1;
        next_s.rsrc = SBC_SRC_CLAMP;
      end else if (s.rst_cnt >= RST_PULSE_CYC - 24'h1) begin
        next_s.rst_drive = 1'b0;
        next_s.rel_watch = 1'b1;
        next_s.clamp_cnt = '0;
      end
    end else if (s.rel_watch) begin
      next_s.clamp_cnt = s.clamp_cnt + 24'h1;
      if (line) begin
        next_s.rel_watch = 1'b0;
        next_s.clamp_cnt = '0;
      end else if (s.clamp_cnt >= CLT_CYC - 24'h1) begin
        to_fs = 1'b1;
        next_s.rsrc = SBC_SRC_CLAMP;
      end
    end
    if (to_fs) begin
      next_s.mode = SBC_M_FAILSAFE;
      next_s.rst_drive = 1'b1;
      next_s.rel_watch = 1'b0;
    end

    if (next_s.rst_drive) begin
      next_s.gate = 1'b0;
    end else if (run) begin
      next_s.gate = link.gate_req;
    end

    // The regulator only stays off in the two modes where the microcontroller must not run.
    next_s.reg_on = (next_s.mode != SBC_M_SLEEP) && (next_s.mode != SBC_M_FAILSAFE);
    next_s.v3_on = v3_raw && !next_s.v3_fault && (next_s.mode != SBC_M_FAILSAFE);
    next_s.wsamp = next_s.v3_on;

    active = link.tar && run;
    txd_dom = !link.txd;
    next_s.ts_q = link.ts;
    ts_rel = s.ts_q && !link.ts;
    next_s.bdom_q = bdom;
    bus_edge = bdom && !s.bdom_q;
    tx_en = active && !link.ts && !s.txd_fault && !s.rec_fault;

    if (!txd_dom && (bus_edge || ts_rel)) begin
      next_s.txd_fault = 1'b0;
    end
    next_s.txd_cnt = txd_dom ? s.txd_cnt + {15'h0, s.txd_cnt != 16'hffff} : 16'h0;
    if (txd_dom && (s.txd_cnt >= SBC_TXD_DOM_CYC - 16'h1)) begin
      next_s.txd_fault = 1'b1;
    end

    if (bdom || ts_rel) begin
      next_s.rec_fault = 1'b0;
    end
    next_s.rec_cnt = (tx_en && txd_dom && !bdom) ? s.rec_cnt + 16'h1 : 16'h0;
    if (tx_en && txd_dom && !bdom && (s.rec_cnt >= SBC_REC_CYC - 16'h1)) begin
      next_s.rec_fault = 1'b1;
    end

    next_s.dom_cnt = bdom ? s.dom_cnt + {15'h0, s.dom_cnt != 16'hffff} : 16'h0;
    next_s.short_gnd = bdom && (s.dom_cnt >= SBC_LIN_DOM_CYC - 16'h1);

    if ({next_s.short_gnd, next_s.rec_fault, next_s.txd_fault} != {s.short_gnd, s.rec_fault, s.txd_fault}) begin
      next_s.evt[0] = 1'b1;
    end

    if (active) begin
      next_s.lin_wake = 1'b0;
      next_s.rx = !bdom;
    end else begin
      next_s.lin_wake = s.lin_wake || bdom;
      next_s.rx = !s.lin_wake;
    end
    next_s.txdrive = tx_en && txd_dom;
    next_s.term = !active ? SBC_TERM_OFF : next_s.short_gnd ? SBC_TERM_WEAK : SBC_TERM_ON;
    next_s.slope = link.slope_low;
    next_s.boost = link.boost;

    if (!link.aux_act) begin
      next_s.aux_oe_b = 1'b1;
      next_s.aux_out = 1'b0;
    end else if (!link.aux_func) begin
      next_s.aux_oe_b = 1'b0;
      next_s.aux_out = next_s.reg_on;
    end else begin
      next_s.aux_oe_b = (next_s.mode != SBC_M_FAILSAFE);
      next_s.aux_out = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= SBC_DEV_RST;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign link.dev_rst_o                = 1'b0;
  assign link.dev_rst_oe_b             = !s.rst_drive;
  assign link.mode                     = s.mode;
  assign link.rsrc                     = s.rsrc;
  assign link.diag                     = {!s.v3_fault, s.txd_fault, s.rec_fault, s.short_gnd};
  assign link.evt                      = s.evt;
  assign link.en_pin                   = s.gate;
  assign link.rxd                      = s.rx;
  assign mcu_supply_regulator          = s.reg_on;
  assign supply_request_out            = 1'b1;
  assign supply_request_out_oe_b       = !s.reg_on;
  assign switched_battery_out          = s.v3_on;
  assign wake_sample_en                = s.wsamp;
  assign lin_tx_drive                  = s.txdrive;
  assign lin_slope_low                 = s.slope;
  assign lin_drive_boost               = s.boost;
  assign bus_termination_pin           = s.term;
  assign external_regulator_ctrl_pin   = s.aux_out;
  assign external_regulator_ctrl_pin_oe_b = s.aux_oe_b;
endmodule

// ### hw/sbc_host.sv
// Host controller end: Avalon-MM slave registers that drive the control bits of the link.
// Assumes the device end shares clk; only the resolved reset line is synchronised.
`timescale 1ns/100ps
module sbc_host
  import sbc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        ce,
  sbc_link_if.host         link,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest
);
  sbc_host_st_t s;
  sbc_host_st_t next_s;
  logic         run;
  logic [31:0]  rd;

  always_comb begin
    next_s = s;
    next_s.s1 = link.rst_line;
    next_s.s2 = s.s1;
    next_s.mode_stb = 1'b0;
    next_s.ack = 1'b0;
    // Events set wins over a same-cycle software clear.
    next_s.sticky = s.sticky | link.evt;
    rd = 32'h0;
    case (avs_address)
      SBC_A_CTRL: begin
        rd = {19'h0, s.ctrl};
      end
      SBC_A_MODE: begin
        rd = {29'h0, link.mode};
      end
      SBC_A_STATUS: begin
        rd = {19'h0, s.s2, link.rxd, link.en_pin, link.diag, link.rsrc, link.mode};
      end
      SBC_A_EVENTS: begin
        rd = {29'h0, s.sticky};
      end
      default: begin
        rd = 32'h0;
      end
    endcase
    if ((avs_read || avs_write) && !s.ack) begin
      next_s.ack = 1'b1;
      next_s.rdata = rd;
    end
    if (avs_write && s.ack) begin
      case (avs_address)
        SBC_A_CTRL: begin
          next_s.ctrl = avs_writedata[12:0];
        end
        SBC_A_MODE: begin
          next_s.mode_req = avs_writedata[2:0];
          next_s.mode_stb = 1'b1;
        end
        SBC_A_EVENTS: begin
          next_s.sticky = (s.sticky & ~avs_writedata[2:0]) | link.evt;
        end
        default: begin
          next_s.ctrl = s.ctrl;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= SBC_HOST_RST;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign run             = (link.mode == SBC_M_NORMAL) || (link.mode == SBC_M_FLASH);
  assign avs_readdata    = s.rdata;
  assign avs_waitrequest = (avs_read || avs_write) && (!s.ack || !ce);
  assign link.gate_req   = s.ctrl[SBC_C_GATE] && run;
  assign link.tar        = s.ctrl[SBC_C_TAR];
  assign link.ts         = s.ctrl[SBC_C_TS];
  assign link.slope_low  = s.ctrl[SBC_C_SLOPE];
  assign link.boost      = s.ctrl[SBC_C_BOOST];
  assign link.aux_act    = s.ctrl[SBC_C_AUXA];
  assign link.aux_func   = s.ctrl[SBC_C_AUXF];
  assign link.v3_mode    = s.ctrl[SBC_C_V3 +: 2];
  assign link.uv_sel     = s.ctrl[SBC_C_UV +: 2];
  assign link.txd        = s.ctrl[SBC_C_TXD];
  assign link.mode_req   = s.mode_req;
  assign link.mode_stb   = s.mode_stb;
  assign link.host_rst_o = 1'b0;
  assign link.host_rst_oe_b = !s.ctrl[SBC_C_HRST];
endmodule

// ### verification/sbc_link_chk.sv
// Link checker for the supervision device and its host.
// Assumes plain copies of link signals, all in the one clk domain.
`timescale 1ns/100ps
module sbc_link_chk
  import sbc_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic [23:0] clt_lim,
  input wire logic [23:0] cht_lim,
  input wire logic       dev_rst_oe_b,
  input wire logic       rst_line,
  input wire logic [2:0] mode,
  input wire logic       en_pin,
  input wire logic       txd,
  input wire logic [3:0] diag,
  input wire logic [2:0] evt
);
  logic [23:0] low_cnt;
  logic [23:0] high_cnt;
  logic [16:0] txd_cnt;
  logic        fs;

  assign fs = (mode == SBC_M_FAILSAFE);

  // Counters replace long repetitions, which the tools unroll slowly.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      low_cnt  <= '0;
      high_cnt <= '0;
      txd_cnt  <= '0;
    end else begin
      low_cnt  <= (dev_rst_oe_b && !rst_line && !fs) ? low_cnt + 24'h1 : '0;
      high_cnt <= (!dev_rst_oe_b && rst_line && !fs) ? high_cnt + 24'h1 : '0;
      txd_cnt  <= txd ? '0 : (txd_cnt[16] ? txd_cnt : txd_cnt + 17'h1);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_gate_clear;
    !dev_rst_oe_b |-> !en_pin;
  endproperty
  a_gate_clear: assert property (p_gate_clear) else $error("enable high in reset");
  property p_gate_hold;
    $rose(dev_rst_oe_b) |-> !en_pin [*3];
  endproperty
  a_gate_hold: assert property (p_gate_hold) else $error("enable high after reset");
  property p_gate_mode;
    $rose(en_pin) |-> (mode == SBC_M_NORMAL || mode == SBC_M_FLASH);
  endproperty
  a_gate_mode: assert property (p_gate_mode) else $error("enable set in wrong mode");
  property p_clamp_low;
    low_cnt <= clt_lim + 24'h8;
  endproperty
  a_clamp_low: assert property (p_clamp_low) else $error("clamped low not caught");
  property p_clamp_high;
    high_cnt <= cht_lim + 24'h8;
  endproperty
  a_clamp_high: assert property (p_clamp_high) else $error("clamped high not caught");
  property p_fs_line;
    fs && $past(fs) |-> !dev_rst_oe_b;
  endproperty
  a_fs_line: assert property (p_fs_line) else $error("line released in fail-safe");
  property p_txd_stuck;
    txd_cnt > 17'(SBC_TXD_DOM_CYC) + 17'h6 |-> diag[2];
  endproperty
  a_txd_stuck: assert property (p_txd_stuck) else $error("stuck transmit not flagged");
  property p_diag_evt;
    $changed(diag[2:0]) |-> ##[0:1] evt[0];
  endproperty
  a_diag_evt: assert property (p_diag_evt) else $error("no event on bus status change");
endmodule

// ### verification/test_sbc_supervision_and_lin_phy_control.sv
// Bench: device and host joined by the link, host driven over Avalon-MM.
// Assumes the shortened timing parameters below; expectations follow from them.
`timescale 1ns/100ps
module test_sbc_supervision_and_lin_phy_control;
  import sbc_pkg::*;
  logic        clk;
  logic        rst_b;
  logic        ce;
  logic        sup;
  logic [23:0] clamp_lim;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [2:0]  v1_uv;
  logic        warn;
  logic        ovl;
  logic        wake;
  logic        bus;
  logic        reg_on;
  logic        sup_oe_b;
  logic        v3;
  logic        ws;
  logic        tx;
  logic        slope;
  logic        boost;
  sbc_term_t   term;
  logic        aux;
  logic        aux_oe_b;
  logic [31:0] q;
  int          failures = 0;
  int          compares = 0;
  int          cyc = 0;
  int          n;
  int          m;

  sbc_link_if link();
  // The pulse must outlast the clamp-high limit, or a clamped line could never be caught.
  sbc_dev #(.RST_PULSE_CYC(24'h28), .CLT_CYC(24'h1e), .CHT_CYC(24'h1e), .V3_P1_CYC(24'h64),
            .V3_ON_CYC(24'h14)) sbc_dev_i (
    .clk, .rst_b, .ce, .link, .v1_uv, .v1_warn_cmp(warn), .v3_overload(ovl), .wake_in(wake),
    .lin_bus_dom(bus), .mcu_supply_regulator(reg_on), .supply_request_out(sup),
    .supply_request_out_oe_b(sup_oe_b), .switched_battery_out(v3), .wake_sample_en(ws),
    .lin_tx_drive(tx), .lin_slope_low(slope), .lin_drive_boost(boost), .bus_termination_pin(term),
    .external_regulator_ctrl_pin(aux), .external_regulator_ctrl_pin_oe_b(aux_oe_b));
  sbc_host sbc_host_i (.clk, .rst_b, .ce, .link, .avs_address, .avs_read, .avs_write,
                       .avs_writedata, .avs_readdata, .avs_waitrequest);
  sbc_link_chk chk_i (
    .clk, .rst_b, .clt_lim(clamp_lim), .cht_lim(clamp_lim), .dev_rst_oe_b(link.dev_rst_oe_b),
    .rst_line(link.rst_line), .mode(link.mode),
    .en_pin(link.en_pin), .txd(link.txd), .diag(link.diag), .evt(link.evt));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic end_of_test();
    $display("Compares %0d, failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // A hang ends the run here; the full sequence needs about 9000 cycles.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      failures++;
      end_of_test();
    end
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask

  // The request is held until waitrequest is sampled low at a rising edge.
  task automatic acc(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    avs_address <= a;
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= d;
    do begin
      @(posedge clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    if (k >= 50) failures++;
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // Two more edges let outputs launched by the access settle before the caller looks.
    repeat (2) @(posedge clk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
  endtask

  task automatic bit_chk(input logic [3:0] a, input int b, input logic e);
    acc(1'b0, a, 32'h0);
    chk($sformatf("reg %h bit %0d", a, b), 32'(q[b]), 32'(e));
  endtask

  task automatic st(input logic [2:0] md, input logic en);
    acc(1'b0, SBC_A_STATUS, 32'h0);
    chk("mode", 32'(q[2:0]), 32'(md));
    chk("enable", 32'(q[10]), 32'(en));
  endtask

  task automatic wait_rel();
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (link.dev_rst_oe_b !== 1'b1 && k < 200);
  endtask

  task automatic wake_up();
    wake <= 1'b1;
    tick(6);
    wake <= 1'b0;
    wait_rel();
  endtask

  initial begin
    rst_b = 1'b0;
    ce = 1'b1;
    clamp_lim = 24'h1e;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    v1_uv = 3'h0;
    warn = 1'b0;
    ovl = 1'b0;
    wake = 1'b0;
    bus = 1'b0;
    link.tb_clamp_low = 1'b0;
    link.tb_clamp_high = 1'b0;
    tick(6);
    rst_b <= 1'b1;
    wait_rel();
    chk("supply req", 32'({reg_on, sup, sup_oe_b}), 32'h6);
    acc(1'b0, SBC_A_CTRL, 32'h0);
    chk("ctrl reset", q, 32'(SBC_CTRL_RST));
    acc(1'b0, 4'h2, 32'h0);
    chk("unmapped", q, 32'h0);
    wr(SBC_A_CTRL, 32'hc61);
    st(SBC_M_START, 1'b0);
    wr(SBC_A_MODE, 32'h1);
    st(SBC_M_NORMAL, 1'b1);
    wr(SBC_A_CTRL, 32'hc7b);
    chk("term on", 32'(term), 32'(SBC_TERM_ON));
    chk("slope boost", 32'({slope, boost}), 32'h3);
    wr(SBC_A_CTRL, 32'h47b);
    bus <= 1'b1;
    tick(6);
    chk("tx drive", 32'(tx), 32'h1);
    wr(SBC_A_CTRL, 32'h47f);
    tick(4);
    chk("listen only", 32'(tx), 32'h0);
    wr(SBC_A_CTRL, 32'h47b);
    tick(2100);
    chk("txd stuck", 32'(tx), 32'h0);
    bit_chk(SBC_A_STATUS, 8, 1'b1);
    bit_chk(SBC_A_EVENTS, 0, 1'b1);
    wr(SBC_A_CTRL, 32'hc7f);
    bus <= 1'b0;
    wr(SBC_A_CTRL, 32'hc7b);
    bit_chk(SBC_A_STATUS, 8, 1'b0);
    wr(SBC_A_CTRL, 32'h47b);
    tick(1100);
    chk("rec clamp", 32'(tx), 32'h0);
    bit_chk(SBC_A_STATUS, 7, 1'b1);
    bus <= 1'b1;
    wr(SBC_A_CTRL, 32'hc7b);
    bit_chk(SBC_A_STATUS, 7, 1'b0);
    tick(4100);
    bit_chk(SBC_A_STATUS, 6, 1'b1);
    chk("term weak", 32'(term), 32'(SBC_TERM_WEAK));
    bus <= 1'b0;
    tick(6);
    chk("term back", 32'(term), 32'(SBC_TERM_ON));
    wr(SBC_A_CTRL, 32'hc61);
    bus <= 1'b1;
    tick(6);
    bus <= 1'b0;
    tick(6);
    chk("offline", 32'({tx, term}), 32'(SBC_TERM_OFF));
    bit_chk(SBC_A_STATUS, 11, 1'b0);
    wr(SBC_A_CTRL, 32'hce1);
    chk("v3 on", 32'(v3), 32'h1);
    ovl <= 1'b1;
    tick(6);
    ovl <= 1'b0;
    chk("v3 off", 32'(v3), 32'h0);
    bit_chk(SBC_A_STATUS, 9, 1'b0);
    bit_chk(SBC_A_EVENTS, 1, 1'b1);
    wr(SBC_A_CTRL, 32'hd61);
    n = 0;
    m = 0;
    repeat (400) begin
      @(posedge clk);
      if (v3 === 1'b1) n++;
      if (ws !== v3) m++;
    end
    chk("wake sampling", 32'(m), 32'h0);
    chk("cyclic", 32'(n >= 40 && n <= 120), 32'h1);
    wr(SBC_A_CTRL, 32'hce3);
    wr(SBC_A_MODE, 32'h4);
    st(SBC_M_SLEEP, 1'b1);
    ovl <= 1'b1;
    tick(6);
    ovl <= 1'b0;
    chk("v3 sleep source", 32'(link.rsrc), 32'(SBC_SRC_V3));
    wait_rel();
    wr(SBC_A_CTRL, 32'hc61);
    wr(SBC_A_EVENTS, 32'h7);
    v1_uv <= 3'h1;
    warn <= 1'b1;
    tick(6);
    chk("unselected", 32'(link.dev_rst_oe_b), 32'h1);
    bit_chk(SBC_A_EVENTS, 2, 1'b1);
    v1_uv <= 3'h4;
    tick(6);
    v1_uv <= 3'h0;
    warn <= 1'b0;
    st(SBC_M_START, 1'b0);
    chk("uv source", 32'(link.rsrc), 32'(SBC_SRC_UV));
    ce <= 1'b0;
    tick(50);
    chk("frozen pulse", 32'(link.dev_rst_oe_b), 32'h0);
    ce <= 1'b1;
    wait_rel();
    chk("en after", 32'(link.en_pin), 32'h0);
    wr(SBC_A_MODE, 32'h1);
    link.tb_clamp_low <= 1'b1;
    tick(100);
    st(SBC_M_FAILSAFE, 1'b0);
    chk("reg off", 32'({reg_on, sup, sup_oe_b}), 32'h3);
    chk("limp", 32'({aux_oe_b, aux}), 32'h0);
    link.tb_clamp_low <= 1'b0;
    wake_up();
    st(SBC_M_START, 1'b0);
    wr(SBC_A_MODE, 32'h1);
    link.tb_clamp_high <= 1'b1;
    v1_uv <= 3'h4;
    tick(6);
    v1_uv <= 3'h0;
    tick(60);
    st(SBC_M_FAILSAFE, 1'b0);
    link.tb_clamp_high <= 1'b0;
    wake_up();
    wr(SBC_A_MODE, 32'h1);
    for (int i = 1; i <= 4; i++) begin
      wr(SBC_A_CTRL, 32'h1c61);
      wr(SBC_A_CTRL, 32'hc61);
      wait_rel();
      if (i == 3) begin
        st(SBC_M_START, 1'b0);
      end
    end
    st(SBC_M_FAILSAFE, 1'b0);
    end_of_test();
  end
endmodule
